//--- hdl/cfd_diag.sv
// cell fault diagnostics: filters, masks, wire scan, fault report, apb registers
//
// Overview of operation
// - undervoltage fault only after the set count of consecutive low samples
// - mask bit one means unconnected; unconnected cells skip undervoltage test
// - new fault while status is zero sends status contents unprompted
// - changing the filter count select restarts all filter counters
// - a cell sample not below the limit restarts that cell's count
// - filter count select resets to 011, meaning eight samples
// - supply or ground open flagged only after consecutive open scans
// - a scan seeing the connection not open restarts its count
// - scan current select: one gives 1mA, zero gives 150uA
// - inputs two to twelve skip open wire test when mask bit set
// - two lowest inputs are always tested for open wire
// - undervoltage limit is a code, 14'h1FFF equals 5V, compared to cells
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
module cfd_diag (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // cell voltage samples
  input  wire logic                        samp_valid,
  input  wire logic [cfd_pkg::CIW-1:0]     samp_cell,
  input  wire logic [cfd_pkg::VW-1:0]      samp_code,
  // supply and ground connection results
  input  wire logic                        conn_valid,
  input  wire logic                        conn_vbat_open,
  input  wire logic                        conn_vss_open,
  // open wire scan
  output logic                             ow_scan_start,
  output logic                             ow_current_1ma,
  output logic      [cfd_pkg::NWIRE-1:0]   ow_enable,
  input  wire logic                        ow_done,
  input  wire logic [cfd_pkg::NWIRE-1:0]   ow_open,
  // unprompted fault report and interrupt
  output logic                             fault_report,
  output logic      [cfd_pkg::FS_W-1:0]    fault_report_data,
  output logic                             irq
);
  import cfd_pkg::*;

  // ==========================================================
  // apb decode
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pready & pwrite;
  assign rd_acc   = psel & penable & pready & ~pwrite;

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      ADDR_FAULT_SETUP, ADDR_CELL_SETUP, ADDR_UV_LIMIT, ADDR_FAULT_STAT,
      ADDR_UV_FAULT, ADDR_OW_FAULT, ADDR_SCAN_STAT, ADDR_COMMAND,
      ADDR_IRQ_STAT, ADDR_IRQ_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] r, input logic w);
    return w && (a == r);
  endfunction

  // ==========================================================
  // configuration registers
  logic [TOT_W-1:0] fault_filter_count_select;
  logic             scan_current_select;
  logic [NCELL-1:0] cell_mask;
  logic [VW-1:0]    uv_limit;
  logic [IRQ_W-1:0] irq_mask;
  logic [TOT_W-1:0] next_tot;
  logic             next_scan_current_select;
  logic [NCELL-1:0] next_cell_mask;
  logic [VW-1:0]    next_uv_limit;
  logic [IRQ_W-1:0] next_irq_mask;
  logic             tot_change;

  // any new select value restarts every filter
  assign tot_change = wr_to(paddr, ADDR_FAULT_SETUP, wr_acc)
                      && (pwdata[TOT_LSB +: TOT_W] != fault_filter_count_select);

  always_comb begin
    next_tot       = fault_filter_count_select;
    next_scan_current_select      = scan_current_select;
    next_cell_mask = cell_mask;
    next_uv_limit  = uv_limit;
    next_irq_mask  = irq_mask;
    if (wr_to(paddr, ADDR_FAULT_SETUP, wr_acc)) begin
      next_tot  = pwdata[TOT_LSB +: TOT_W];
      next_scan_current_select = pwdata[SCAN_CURRENT_SELECT_BIT];
    end
    if (wr_to(paddr, ADDR_CELL_SETUP, wr_acc)) begin
      next_cell_mask = pwdata[NCELL-1:0];
    end
    if (wr_to(paddr, ADDR_UV_LIMIT, wr_acc)) begin
      next_uv_limit = pwdata[VW-1:0];
    end
    if (wr_to(paddr, ADDR_IRQ_MASK, wr_acc)) begin
      next_irq_mask = pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_filter_count_select       <= TOT_RST;
      scan_current_select      <= SCAN_CURRENT_SELECT_RST;
      cell_mask <= MASK_RST;
      uv_limit  <= UV_LIMIT_RST;
      irq_mask  <= '0;
    end else begin
      fault_filter_count_select       <= next_tot;
      scan_current_select      <= next_scan_current_select;
      cell_mask <= next_cell_mask;
      uv_limit  <= next_uv_limit;
      irq_mask  <= next_irq_mask;
    end
  end

  // ==========================================================
  // filters: one per cell, one per connection
  logic [FCW-1:0] thresh;
  logic [NCELL-1:0] uv_trip;
  logic [1:0]       conn_trip;
  logic [1:0]       conn_fail;
  assign thresh    = tot_threshold(fault_filter_count_select);
  assign conn_fail = {conn_vss_open, conn_vbat_open};

  genvar gi;
  generate
    for (gi = 0; gi < NCELL; gi++) begin : g_cell
      // masked cells take no sample at all, so they never count
      cfd_filter #(.CW(FCW)) u_uv (
        .pclk      (pclk),
        .presetn   (presetn),
        .restart   (tot_change),
        .threshold (thresh),
        .sample    (samp_valid && samp_cell == CIW'(gi) && !cell_mask[gi]),
        .fail      (samp_code < uv_limit),
        .trip      (uv_trip[gi])
      );
    end
    for (gi = 0; gi < 2; gi++) begin : g_conn
      cfd_filter #(.CW(FCW)) u_conn (
        .pclk      (pclk),
        .presetn   (presetn),
        .restart   (tot_change),
        .threshold (thresh),
        .sample    (conn_valid),
        .fail      (conn_fail[gi]),
        .trip      (conn_trip[gi])
      );
    end
  endgenerate

  // ==========================================================
  // wire scan sequencer
  cfd_wscan_e       ws_state;
  cfd_wscan_e       next_ws_state;
  logic             next_ow_start;
  logic [NWIRE-1:0] next_ow_enable;
  logic             scan_done_evt;

  always_comb begin
    next_ws_state = ws_state;
    next_ow_start = 1'b0;
    scan_done_evt = 1'b0;
    // lowest two inputs always tested, the rest follow the mask
    next_ow_enable = {~cell_mask[NCELL-1:OW_FIXED-1], {OW_FIXED{1'b1}}};
    case (ws_state)
      CFD_WS_IDLE: begin
        if (wr_to(paddr, ADDR_COMMAND, wr_acc) && pwdata[CMD_WSCAN_BIT]) begin
          next_ws_state = CFD_WS_RUN;
          next_ow_start = 1'b1;
        end
      end
      CFD_WS_RUN: begin
        if (ow_done) begin
          next_ws_state = CFD_WS_IDLE;
          scan_done_evt = 1'b1;
        end
      end
      default: next_ws_state = CFD_WS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_state       <= CFD_WS_IDLE;
      ow_scan_start  <= 1'b0;
      ow_enable      <= {NWIRE{1'b1}};
      ow_current_1ma <= SCAN_CURRENT_SELECT_RST;
    end else begin
      ws_state       <= next_ws_state;
      ow_scan_start  <= next_ow_start;
      ow_enable      <= next_ow_enable;
      ow_current_1ma <= scan_current_select;
    end
  end

  // ==========================================================
  // fault flags, report and interrupt
  logic [FS_W-1:0]  fault_status;
  logic [NCELL-1:0] uv_fault;
  logic [NWIRE-1:0] ow_fault;
  logic [IRQ_W-1:0] irq_status;
  logic [FS_W-1:0]  next_fault_status;
  logic [FS_W-1:0]  fs_set;
  logic [NCELL-1:0] next_uv_fault;
  logic [NWIRE-1:0] next_ow_fault;
  logic [NWIRE-1:0] ow_hit;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_clr;
  logic             next_report;

  assign ow_hit = (ws_state == CFD_WS_RUN && ow_done) ? (ow_open & ow_enable) : '0;

  // write one to clear; a set in the same cycle wins
  always_comb begin
    fs_set          = '0;
    fs_set[FS_UV]   = |uv_trip;
    fs_set[FS_OW]   = |ow_hit;
    fs_set[FS_VBAT] = conn_trip[0];
    fs_set[FS_VSS]  = conn_trip[1];
    next_fault_status = fault_status;
    next_uv_fault     = uv_fault;
    next_ow_fault     = ow_fault;
    if (wr_to(paddr, ADDR_FAULT_STAT, wr_acc)) begin
      next_fault_status = fault_status & ~pwdata[FS_W-1:0];
    end
    if (wr_to(paddr, ADDR_UV_FAULT, wr_acc)) begin
      next_uv_fault = uv_fault & ~pwdata[NCELL-1:0];
    end
    if (wr_to(paddr, ADDR_OW_FAULT, wr_acc)) begin
      next_ow_fault = ow_fault & ~pwdata[NWIRE-1:0];
    end
    next_fault_status = next_fault_status | fs_set;
    next_uv_fault     = next_uv_fault | uv_trip;
    next_ow_fault     = next_ow_fault | ow_hit;
    next_report = (fault_status == '0) && (next_fault_status != '0);
    // read clears only the bits that the read returned
    irq_clr = rd_acc && paddr == ADDR_IRQ_STAT ? prdata[IRQ_W-1:0] : '0;
    next_irq_status = (irq_status & ~irq_clr)
                      | {scan_done_evt, fs_set & ~fault_status};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_status      <= '0;
      uv_fault          <= '0;
      ow_fault          <= '0;
      irq_status        <= '0;
      fault_report      <= 1'b0;
      fault_report_data <= '0;
      irq               <= 1'b0;
    end else begin
      fault_status      <= next_fault_status;
      uv_fault          <= next_uv_fault;
      ow_fault          <= next_ow_fault;
      irq_status        <= next_irq_status;
      fault_report      <= next_report;
      fault_report_data <= next_report ? next_fault_status : fault_report_data;
      // next mask too, so a mask write and the level agree in the same cycle
      irq               <= |(next_irq_status & next_irq_mask);
    end
  end

  // ==========================================================
  // apb answer: data captured in setup, pready in access
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  always_comb begin
    next_pready  = setup_ph;
    next_pslverr = setup_ph && !addr_mapped(paddr);
    next_prdata  = '0;
    if (setup_ph && !pwrite) begin
      case (paddr)
        ADDR_FAULT_SETUP: next_prdata = 32'({scan_current_select, fault_filter_count_select});
        ADDR_CELL_SETUP:  next_prdata = 32'(cell_mask);
        ADDR_UV_LIMIT:    next_prdata = 32'(uv_limit);
        ADDR_FAULT_STAT:  next_prdata = 32'(fault_status);
        ADDR_UV_FAULT:    next_prdata = 32'(uv_fault);
        ADDR_OW_FAULT:    next_prdata = 32'(ow_fault);
        ADDR_SCAN_STAT:   next_prdata = 32'(ws_state == CFD_WS_RUN);
        ADDR_IRQ_STAT:    next_prdata = 32'(irq_status);
        ADDR_IRQ_MASK:    next_prdata = 32'(irq_mask);
        default:          next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // checks
  sequence s_fault_from_zero;
    fault_status == '0 ##1 fault_status != '0;
  endsequence

  a_report_unprompted: assert property (@(posedge pclk) disable iff (!presetn)
    s_fault_from_zero |-> fault_report && fault_report_data == fault_status)
    else $error("no report when status left zero");

  a_report_only_zero: assert property (@(posedge pclk) disable iff (!presetn)
    fault_report |-> $past(fault_status) == '0)
    else $error("report sent while status already nonzero");

  a_uv_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    |($past(uv_fault) & ~uv_fault) |-> $past(wr_acc) && $past(paddr) == ADDR_UV_FAULT)
    else $error("undervoltage flag dropped without host clear");

  a_uv_masked_cell: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $past(uv_trip) == '0 || ($past(uv_trip, 1) & cell_mask) == '0
        || $past(cell_mask) != cell_mask)
    else $error("masked cell raised undervoltage");

  a_ow_low_inputs: assert property (@(posedge pclk) disable iff (!presetn)
    ow_enable[OW_FIXED-1:0] == {OW_FIXED{1'b1}})
    else $error("lowest inputs not tested");

  a_ow_mask_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ow_enable[NWIRE-1:OW_FIXED] == ~$past(cell_mask[NCELL-1:OW_FIXED-1]))
    else $error("open wire enable disagrees with mask");

  a_scan_current_select_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ow_current_1ma == $past(scan_current_select))
    else $error("scan current select not applied");

  a_tot_default: assert property (@(posedge pclk)
    $rose(presetn) |-> fault_filter_count_select == TOT_RST && thresh == FCW'(8))
    else $error("filter select reset value wrong");

  a_wscan_start: assert property (@(posedge pclk) disable iff (!presetn)
    ow_scan_start |-> ws_state == CFD_WS_RUN ##1 !ow_scan_start)
    else $error("wire scan start not a single pulse in run");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |(irq_status & irq_mask))
    else $error("interrupt does not follow masked status");

endmodule

//--- hdl/cfd_pkg.sv
// constants, register map and types of the cell fault diagnostics block
package cfd_pkg;

  // ==========================================================
  // sizes
  localparam int NCELL = 12;
  localparam int NWIRE = 13;
  localparam int CIW   = 4;
  localparam int VW    = 14;
  localparam int OW_FIXED = 2;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_FAULT_SETUP = 8'h00;
  localparam logic [7:0] ADDR_CELL_SETUP  = 8'h04;
  localparam logic [7:0] ADDR_UV_LIMIT    = 8'h08;
  localparam logic [7:0] ADDR_FAULT_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_UV_FAULT    = 8'h10;
  localparam logic [7:0] ADDR_OW_FAULT    = 8'h14;
  localparam logic [7:0] ADDR_SCAN_STAT   = 8'h18;
  localparam logic [7:0] ADDR_COMMAND     = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h24;

  // ==========================================================
  // field positions
  localparam int TOT_LSB  = 0;
  localparam int TOT_W    = 3;
  localparam int SCAN_CURRENT_SELECT_BIT = 3;
  localparam int CMD_WSCAN_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int FS_UV    = 0;
  localparam int FS_OW    = 1;
  localparam int FS_VBAT  = 2;
  localparam int FS_VSS   = 3;
  localparam int FS_W     = 4;
  localparam int IRQ_DONE = 4;
  localparam int IRQ_W    = 5;

  // ==========================================================
  // reset values; uv limit full scale 14'h1FFF stands for 5 V
  localparam logic [TOT_W-1:0] TOT_RST  = 3'b011;
  localparam logic             SCAN_CURRENT_SELECT_RST = 1'b1;
  localparam logic [VW-1:0]    UV_FULL_SCALE = 14'h1FFF;
  localparam logic [VW-1:0]    UV_LIMIT_RST  = 14'h0000;
  localparam logic [NCELL-1:0] MASK_RST = 12'h000;

  // ==========================================================
  // filter depth: 2 to the power of the select code
  localparam int FCW = 8;
  function automatic logic [FCW-1:0] tot_threshold(input logic [TOT_W-1:0] t);
    return FCW'(1) << t;
  endfunction

  typedef enum logic [1:0] {
    CFD_WS_IDLE = 2'b01,
    CFD_WS_RUN  = 2'b10
  } cfd_wscan_e;

endpackage

//--- hdl/cfd_filter.sv
// consecutive-sample fault filter for one monitored condition
`timescale 1ns/1ns
module cfd_filter #(
  parameter int CW = 8
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // control
  input  wire logic          restart,
  input  wire logic [CW-1:0] threshold,
  // samples
  input  wire logic          sample,
  input  wire logic          fail,
  // result
  output logic               trip
);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_trip;

  // ==========================================================
  // counter
  // the failing sample that brings the count to the threshold trips; count saturates
  always_comb begin
    next_count = count;
    next_trip  = 1'b0;
    if (restart) begin
      next_count = '0;
    end else if (sample) begin
      if (!fail) begin
        next_count = '0;
      end else if (count + CW'(1) >= threshold) begin
        next_count = threshold;
        next_trip  = 1'b1;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      trip  <= 1'b0;
    end else begin
      count <= next_count;
      trip  <= next_trip;
    end
  end

  // ==========================================================
  // checks
  sequence s_good_sample;
    sample && !fail && !restart;
  endsequence

  a_pass_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_good_sample |=> count == '0 && !trip)
    else $error("passing sample did not clear filter");

  a_restart_clears: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> count == '0 && !trip)
    else $error("filter restart ignored");

  a_trip_cause: assert property (@(posedge pclk) disable iff (!presetn)
    trip |-> $past(sample) && $past(fail) && $past(count) + CW'(1) >= $past(threshold))
    else $error("filter tripped without enough failing samples");

endmodule

//--- verification/cfd_front.sv
// measurement front end model: cell samples, connection results, wire scanner
`timescale 1ns/1ns
module cfd_front (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // cell samples
  output logic             samp_valid,
  output logic [3:0]       samp_cell,
  output logic [13:0]      samp_code,
  // connection results
  output logic             conn_valid,
  output logic             conn_vbat_open,
  output logic             conn_vss_open,
  // wire scanner
  input  wire logic        ow_scan_start,
  output logic             ow_done,
  output logic [12:0]      ow_open
);
  int          scan_wait = 3;
  int          cnt;
  logic [12:0] open_pat = 13'h0000;

  // quiet lines at time zero
  initial begin
    samp_valid = 1'h0;
    samp_cell = 4'h0;
    samp_code = 14'h0000;
    conn_valid = 1'h0;
    conn_vbat_open = 1'h0;
    conn_vss_open = 1'h0;
  end

  // ==========================================
  // n back to back samples of one cell, then stale data turned round
  task automatic burst(input logic [3:0] c, input logic [13:0] code, input int n);
    samp_cell <= c;
    samp_code <= code;
    samp_valid <= 1'h1;
    repeat (n) @(posedge pclk);
    samp_valid <= 1'h0;
    samp_code <= ~code;
    @(posedge pclk);
  endtask

  // one connection result, then the levels are no longer meaningful
  task automatic conn(input logic v, input logic s);
    conn_vbat_open <= v;
    conn_vss_open <= s;
    conn_valid <= 1'h1;
    @(posedge pclk);
    conn_valid <= 1'h0;
    conn_vbat_open <= ~v;
    conn_vss_open <= ~s;
    @(posedge pclk);
  endtask

  // ==========================================
  // scanner takes scan_wait cycles; result only meaningful with done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ow_done <= 1'h0;
    end else begin
      cnt <= ow_scan_start ? scan_wait : (cnt > 0 ? cnt - 1 : 0);
      ow_done <= (cnt == 1);
    end
  end
  assign ow_open = ow_done ? open_pat : ~open_pat;
endmodule

//--- verification/tb.sv
// self-checking bench for the cell fault diagnostics block
`timescale 1ns/1ns
module tb;
  import cfd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        samp_valid, conn_valid, conn_vbat_open, conn_vss_open;
  logic        ow_scan_start, ow_current_1ma, ow_done, fault_report, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  samp_cell, fault_report_data, rep_data;
  logic [13:0] samp_code;
  logic [12:0] ow_enable, ow_open;
  int          n_mismatch, n_compared, n_rep, k;

  cfd_diag i_cfd_diag (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .samp_valid(samp_valid), .samp_cell(samp_cell),
    .samp_code(samp_code), .conn_valid(conn_valid), .conn_vbat_open(conn_vbat_open),
    .conn_vss_open(conn_vss_open), .ow_scan_start(ow_scan_start),
    .ow_current_1ma(ow_current_1ma), .ow_enable(ow_enable), .ow_done(ow_done),
    .ow_open(ow_open), .fault_report(fault_report),
    .fault_report_data(fault_report_data), .irq(irq));
  cfd_front i_cfd_front (.pclk(pclk), .presetn(presetn), .samp_valid(samp_valid),
    .samp_cell(samp_cell), .samp_code(samp_code), .conn_valid(conn_valid),
    .conn_vbat_open(conn_vbat_open), .conn_vss_open(conn_vss_open),
    .ow_scan_start(ow_scan_start), .ow_done(ow_done), .ow_open(ow_open));

  // 25 MHz clock
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  // count unprompted reports, keep the last payload; mid-cycle avoids the edge race
  always @(negedge pclk) begin
    if (fault_report === 1'h1) begin
      n_rep++;
      rep_data = fault_report_data;
    end
  end

  // ==========================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer; no wait state count is assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    logic rdy;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    t = 0;
    // answer is registered: the value standing before the edge is the one accepted
    do begin
      @(negedge pclk);
      rdy = pready;
      r = prdata;
      err = pslverr;
      @(posedge pclk);
      t++;
    end while (rdy !== 1'h1 && t < 50);
    if (rdy !== 1'h1) begin
      n_mismatch++;
      complete_run;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h00000000);
    chk(r, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ==========================================
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'h0;
    idle(8);
    presetn <= 1'h1;
    @(posedge pclk);
    // reset state and an unmapped access
    chk(32'(ow_current_1ma), 32'h1);
    chk(32'(ow_enable), 32'h1FFF);
    rd(ADDR_FAULT_SETUP, 32'h0000000B);
    rd(ADDR_UV_LIMIT, 32'h00000000);
    apb(1'h0, 8'hFC, 32'h00000000);
    chk(32'(err), 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0000001F);
    wr(ADDR_UV_LIMIT, 32'h00000064);
    // two cells interleaved, a sample at the limit restarts one
    for (int i = 0; i < 7; i++) begin
      i_cfd_front.burst(4'h3, 14'h0032, 1);
      i_cfd_front.burst(4'h4, 14'h0032, 1);
    end
    i_cfd_front.burst(4'h3, 14'h0064, 1);
    i_cfd_front.burst(4'h3, 14'h0032, 7);
    idle(3);
    rd(ADDR_UV_FAULT, 32'h00000000);
    chk(n_rep, 0);
    i_cfd_front.burst(4'h3, 14'h0063, 1);
    idle(3);
    chk(n_rep, 1);
    chk(32'(rep_data), 32'h1);
    chk(32'(irq), 32'h1);
    rd(ADDR_FAULT_STAT, 32'h00000001);
    rd(ADDR_UV_FAULT, 32'h00000008);
    i_cfd_front.burst(4'h3, 14'h00C8, 1);
    idle(3);
    rd(ADDR_UV_FAULT, 32'h00000008);
    rd(ADDR_IRQ_STAT, 32'h00000001);
    idle(2);
    chk(32'(irq), 32'h0);
    // host clears cell bits first, then the summary
    wr(ADDR_UV_FAULT, 32'h00000008);
    wr(ADDR_FAULT_STAT, 32'h00000001);
    rd(ADDR_FAULT_STAT, 32'h00000000);
    // select changed and restored restarts the counts
    i_cfd_front.burst(4'h5, 14'h0032, 4);
    wr(ADDR_FAULT_SETUP, 32'h0000000A);
    wr(ADDR_FAULT_SETUP, 32'h0000000B);
    i_cfd_front.burst(4'h5, 14'h0032, 4);
    idle(3);
    rd(ADDR_UV_FAULT, 32'h00000000);
    i_cfd_front.burst(4'h5, 14'h0032, 4);
    idle(3);
    rd(ADDR_UV_FAULT, 32'h00000020);
    chk(n_rep, 2);
    wr(ADDR_UV_FAULT, 32'h00000020);
    wr(ADDR_FAULT_STAT, 32'h00000001);
    rd(ADDR_IRQ_STAT, 32'h00000001);
    // depth one, masked cells, full scale limit
    wr(ADDR_FAULT_SETUP, 32'h00000008);
    wr(ADDR_CELL_SETUP, 32'h00000041);
    wr(ADDR_UV_LIMIT, 32'h00001FFF);
    idle(2);
    chk(32'(ow_enable), 32'h1F7F);
    i_cfd_front.burst(4'h6, 14'h0000, 2);
    i_cfd_front.burst(4'h0, 14'h0000, 2);
    i_cfd_front.burst(4'h1, 14'h1FFF, 1);
    i_cfd_front.burst(4'h2, 14'h1FFE, 1);
    idle(3);
    rd(ADDR_UV_FAULT, 32'h00000004);
    wr(ADDR_UV_FAULT, 32'h00000004);
    wr(ADDR_FAULT_STAT, 32'h00000001);
    rd(ADDR_IRQ_STAT, 32'h00000001);
    // connection filter, depth two
    wr(ADDR_FAULT_SETUP, 32'h00000009);
    i_cfd_front.conn(1'h1, 1'h0);
    i_cfd_front.conn(1'h0, 1'h0);
    i_cfd_front.conn(1'h1, 1'h0);
    idle(3);
    rd(ADDR_FAULT_STAT, 32'h00000000);
    i_cfd_front.conn(1'h1, 1'h1);
    idle(3);
    rd(ADDR_FAULT_STAT, 32'h00000004);
    chk(n_rep, 4);
    i_cfd_front.conn(1'h0, 1'h1);
    idle(3);
    rd(ADDR_FAULT_STAT, 32'h0000000C);
    chk(n_rep, 4);
    wr(ADDR_FAULT_STAT, 32'h0000000C);
    rd(ADDR_FAULT_STAT, 32'h00000000);
    rd(ADDR_IRQ_STAT, 32'h0000000C);
    // wire scans at low current, slow then prompt scanner
    wr(ADDR_FAULT_SETUP, 32'h00000003);
    idle(2);
    chk(32'(ow_current_1ma), 32'h0);
    i_cfd_front.open_pat = 13'h1081;
    for (int w = 0; w < 13; w += 9) begin
      i_cfd_front.scan_wait = (w == 0) ? 30 : 2;
      wr(ADDR_COMMAND, 32'h00000001);
      if (w == 0) rd(ADDR_SCAN_STAT, 32'h00000001);
      k = 0;
      do begin
        apb(1'h0, ADDR_SCAN_STAT, 32'h00000000);
        k++;
      end while (r[0] !== 1'h0 && k < 100);
      if (k >= 100) begin
        n_mismatch++;
        complete_run;
      end
      rd(ADDR_OW_FAULT, 32'h00001001);
      rd(ADDR_FAULT_STAT, 32'h00000002);
      rd(ADDR_IRQ_STAT, 32'h00000012);
      wr(ADDR_OW_FAULT, 32'h00001001);
      wr(ADDR_FAULT_STAT, 32'h00000002);
    end
    complete_run;
  end
endmodule
